// ===== uvc_pkg.sv
// package: constants, gain table and states for the volume step control block
package uvc_pkg;
    localparam int         UVC_TICK_DIV_LOG2 = 13;
    localparam int         UVC_OSC_KHZ       = 250;
    localparam int         UVC_CLK_KHZ       = 10000;
    localparam int         UVC_OSC_DIV       = UVC_CLK_KHZ / UVC_OSC_KHZ;
    localparam int         UVC_FIRST_TICKS   = 1;
    localparam int         UVC_SECOND_TICKS  = 10;
    localparam int         UVC_REPEAT_TICKS  = 4;
    localparam int         UVC_STEPS         = 32;
    localparam logic [4:0] UVC_IDX_TOP       = 5'h00;
    localparam logic [4:0] UVC_IDX_BOTTOM    = 5'h1F;
    localparam logic [4:0] UVC_IDX_DEFAULT   = 5'h08;
    localparam logic [4:0] UVC_ONE           = 5'h01;
    localparam logic [7:0] UVC_ADDR_CTRL     = 8'h00;
    localparam logic [7:0] UVC_ADDR_STAT     = 8'h04;
    localparam logic [7:0] UVC_ADDR_IRQ      = 8'h08;
    localparam logic [7:0] UVC_ADDR_MASK     = 8'h0C;
    localparam logic [1:0] UVC_RESP_OKAY     = 2'h0;
    localparam logic [1:0] UVC_RESP_SLVERR   = 2'h2;
    localparam int         UVC_IRQ_W         = 5;

    typedef enum logic [1:0] {
        UVC_ST_IDLE   = 2'b00,
        UVC_ST_FIRST  = 2'b01,
        UVC_ST_SECOND = 2'b10,
        UVC_ST_REPEAT = 2'b11
    } uvc_state_t;

    // gain of each step in tenths of a dB (signed), index 0 is step 1
    function automatic logic signed [10:0] uvc_gain_tenths(input logic [4:0] idx);
        logic signed [10:0] g;
        g = 11'sd0;
        if (idx == 5'h1F) begin
            g = -11'sd800;
        end else if (idx >= 5'h15) begin
            g = -11'sd80 - 11'(20 * (int'(idx) - 21));
        end else if (idx == 5'h09) begin
            g = 11'sd104;
        end else begin
            g = 11'sd240 - 11'(15 * int'(idx));
        end
        return g;
    endfunction : uvc_gain_tenths
endpackage : uvc_pkg

// ===== uvc_sync.sv
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module uvc_sync
    import uvc_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic din,
    output logic      dout
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic dout_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg   <= RESET_VAL;
            s2_reg   <= RESET_VAL;
            s3_reg   <= RESET_VAL;
            dout_reg <= RESET_VAL;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout_reg <= s3_reg;
            end
        end
    end

    assign dout = dout_reg;
endmodule : uvc_sync

// ===== uvc_volume_step_control.sv
// volume step control with protection gating and an AXI4-Lite status slave
`timescale 1ns/100ps
module uvc_volume_step_control
    import uvc_pkg::*;
#(
    parameter int TICK_DIV_LOG2 = UVC_TICK_DIV_LOG2,
    parameter int OSC_DIV       = UVC_OSC_DIV
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        volume_up_n,
    input  wire logic        volume_down_n,
    input  wire logic        shutdown_request_n,
    input  wire logic        supply_low_lockout,
    input  wire logic        short_circuit_guard,
    input  wire logic        over_temp_trip,
    input  wire logic        over_temp_cooled,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [4:0]       gain_index,
    output logic signed [10:0] gain_tenths_db,
    output logic             amp_enable,
    output logic             outputs_enable,
    output logic             irq
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic up_n_s;
    logic down_n_s;
    logic sd_n_s;
    logic supply_low_lockout_s;
    logic scp_s;
    logic ot_trip_s;
    logic ot_cool_s;

    uvc_sync #(.RESET_VAL(1'b1)) u_sync_up (.aclk(aclk), .aresetn(aresetn), .din(volume_up_n), .dout(up_n_s));
    uvc_sync #(.RESET_VAL(1'b1)) u_sync_dn (.aclk(aclk), .aresetn(aresetn), .din(volume_down_n), .dout(down_n_s));
    // reset value low keeps the amplifier off until a real high is seen
    uvc_sync #(.RESET_VAL(1'b0)) u_sync_sd (.aclk(aclk), .aresetn(aresetn), .din(shutdown_request_n),
                                            .dout(sd_n_s));
    uvc_sync #(.RESET_VAL(1'b0)) u_sync_uv (.aclk(aclk), .aresetn(aresetn), .din(supply_low_lockout),
                                            .dout(supply_low_lockout_s));
    uvc_sync #(.RESET_VAL(1'b0)) u_sync_sc (.aclk(aclk), .aresetn(aresetn), .din(short_circuit_guard),
                                            .dout(scp_s));
    uvc_sync #(.RESET_VAL(1'b0)) u_sync_ot (.aclk(aclk), .aresetn(aresetn), .din(over_temp_trip),
                                            .dout(ot_trip_s));
    uvc_sync #(.RESET_VAL(1'b0)) u_sync_oc (.aclk(aclk), .aresetn(aresetn), .din(over_temp_cooled),
                                            .dout(ot_cool_s));

    // ------------------------------------------------------------
    // oscillator enable and volume tick divider
    // ------------------------------------------------------------
    logic [7:0]               osc_cnt_reg;
    logic [TICK_DIV_LOG2-1:0] tick_cnt_reg;
    logic                     osc_en;
    logic                     tick_en;

    // osc_en marks one period of the switching oscillator
    assign osc_en  = (osc_cnt_reg == 8'(OSC_DIV - 1));
    assign tick_en = osc_en && (&tick_cnt_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_cnt_reg  <= 8'h00;
            tick_cnt_reg <= '0;
        end else begin
            osc_cnt_reg <= osc_en ? 8'h00 : osc_cnt_reg + 8'h01;
            if (osc_en) begin
                tick_cnt_reg <= tick_cnt_reg + TICK_DIV_LOG2'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // hold timing state machine
    // ------------------------------------------------------------
    uvc_state_t state_reg;
    uvc_state_t state_next;
    logic [3:0] wait_reg;
    logic [3:0] wait_next;
    logic       dir_up_reg;
    logic       dir_up_next;
    logic [4:0] idx_reg;
    logic       step_now;
    logic       up_req;
    logic       dn_req;
    logic       one_req;
    logic       req_up;

    assign up_req  = !up_n_s && down_n_s;
    assign dn_req  = !down_n_s && up_n_s;
    assign one_req = up_req ^ dn_req;
    assign req_up  = up_req;

    // SECOND and REPEAT waits count down to one, FIRST to zero: step on the last tick
    always_comb begin
        state_next  = state_reg;
        wait_next   = wait_reg;
        dir_up_next = dir_up_reg;
        step_now    = 1'b0;
        if (tick_en) begin
            // release or a change of direction restarts the sequence
            if (!one_req || (state_reg != UVC_ST_IDLE && req_up != dir_up_reg)) begin
                state_next = UVC_ST_IDLE;
                wait_next  = 4'h0;
            end else begin
                case (state_reg)
                    UVC_ST_IDLE: begin
                        dir_up_next = req_up;
                        state_next  = UVC_ST_FIRST;
                        wait_next   = 4'(UVC_FIRST_TICKS - 1);
                        if (UVC_FIRST_TICKS == 1) begin
                            step_now   = 1'b1;
                            state_next = UVC_ST_SECOND;
                            wait_next  = 4'(UVC_SECOND_TICKS);
                        end
                    end
                    UVC_ST_FIRST: begin
                        if (wait_reg == 4'h0) begin
                            step_now   = 1'b1;
                            state_next = UVC_ST_SECOND;
                            wait_next  = 4'(UVC_SECOND_TICKS);
                        end else begin
                            wait_next = wait_reg - 4'h1;
                        end
                    end
                    UVC_ST_SECOND: begin
                        if (wait_reg == 4'h1) begin
                            step_now   = 1'b1;
                            state_next = UVC_ST_REPEAT;
                            wait_next  = 4'(UVC_REPEAT_TICKS);
                        end else begin
                            wait_next = wait_reg - 4'h1;
                        end
                    end
                    UVC_ST_REPEAT: begin
                        if (wait_reg == 4'h1) begin
                            step_now  = 1'b1;
                            wait_next = 4'(UVC_REPEAT_TICKS);
                        end else begin
                            wait_next = wait_reg - 4'h1;
                        end
                    end
                    default: begin
                        state_next = UVC_ST_IDLE;
                        wait_next  = 4'h0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // gain index
    // ------------------------------------------------------------
    logic at_top;
    logic at_bottom;
    logic idx_inc;
    logic idx_dec;

    assign at_top    = (idx_reg == UVC_IDX_TOP);
    assign at_bottom = (idx_reg == UVC_IDX_BOTTOM);
    // index 0 is the loudest step, so raising lowers the index
    assign idx_dec   = step_now && state_next != UVC_ST_IDLE && dir_up_next && !at_top;
    assign idx_inc   = step_now && state_next != UVC_ST_IDLE && !dir_up_next && !at_bottom;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg  <= UVC_ST_IDLE;
            wait_reg   <= 4'h0;
            dir_up_reg <= 1'b0;
            idx_reg    <= UVC_IDX_DEFAULT;
        end else begin
            state_reg  <= state_next;
            wait_reg   <= wait_next;
            dir_up_reg <= dir_up_next;
            // index logic ignores shutdown so the setting survives it
            if (idx_dec) begin
                idx_reg <= idx_reg - UVC_ONE;
            end else if (idx_inc) begin
                idx_reg <= idx_reg + UVC_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // protection gating
    // ------------------------------------------------------------
    logic ot_fault_reg;
    logic amp_en_reg;
    logic out_en_reg;
    logic [4:0]  gidx_reg;
    logic signed [10:0] gdb_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ot_fault_reg <= 1'b0;
            amp_en_reg   <= 1'b0;
            out_en_reg   <= 1'b0;
            gidx_reg     <= UVC_IDX_DEFAULT;
            gdb_reg      <= '0;
        end else begin
            if (ot_trip_s) begin
                ot_fault_reg <= 1'b1;
            end else if (ot_cool_s) begin
                ot_fault_reg <= 1'b0;
            end
            amp_en_reg <= sd_n_s;
            out_en_reg <= sd_n_s && !supply_low_lockout_s && !scp_s && !(ot_trip_s || ot_fault_reg);
            gidx_reg   <= idx_reg;
            gdb_reg    <= uvc_gain_tenths(idx_reg);
        end
    end

    assign gain_index     = gidx_reg;
    assign gain_tenths_db = gdb_reg;
    assign amp_enable     = amp_en_reg;
    assign outputs_enable = out_en_reg;

    // ------------------------------------------------------------
    // interrupts: step, lockout, short, over-temp, shutdown entry
    // ------------------------------------------------------------
    logic [UVC_IRQ_W-1:0] irq_stat_reg;
    logic [UVC_IRQ_W-1:0] irq_mask_reg;
    logic [UVC_IRQ_W-1:0] irq_evt;
    logic [UVC_IRQ_W-1:0] irq_clr;
    logic                 sd_prev_reg;

    assign irq_evt = {sd_prev_reg && !sd_n_s, ot_trip_s, scp_s, supply_low_lockout_s, idx_inc || idx_dec};
    assign irq     = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic        wr_go;
    logic        wr_mask;
    logic        wr_irq;
    logic        wr_ok;
    logic        rd_go;
    logic [31:0] rd_word;
    logic        rd_ok;

    // a write completes once address and data are both held
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign wr_go   = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_ok   = aw_addr_reg == UVC_ADDR_IRQ || aw_addr_reg == UVC_ADDR_MASK ||
                     aw_addr_reg == UVC_ADDR_CTRL || aw_addr_reg == UVC_ADDR_STAT;
    assign wr_irq  = wr_go && aw_addr_reg == UVC_ADDR_IRQ && w_strb_reg[0];
    assign wr_mask = wr_go && aw_addr_reg == UVC_ADDR_MASK && w_strb_reg[0];
    assign irq_clr = wr_irq ? w_data_reg[UVC_IRQ_W-1:0] : '0;
    assign s_axi_arready = !rvalid_reg;
    assign rd_go   = s_axi_arvalid && !rvalid_reg;
    assign rd_ok   = s_axi_araddr == UVC_ADDR_CTRL || s_axi_araddr == UVC_ADDR_STAT ||
                     s_axi_araddr == UVC_ADDR_IRQ || s_axi_araddr == UVC_ADDR_MASK;
    assign rd_word = (s_axi_araddr == UVC_ADDR_CTRL) ? {27'h0, idx_reg} :
                     (s_axi_araddr == UVC_ADDR_STAT) ? {21'h0, gdb_reg} :
                     (s_axi_araddr == UVC_ADDR_IRQ)  ? {27'h0, irq_stat_reg} :
                     (s_axi_araddr == UVC_ADDR_MASK) ? {27'h0, irq_mask_reg} : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_data_reg   <= 32'h0;
            w_strb_reg   <= 4'h0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= UVC_RESP_OKAY;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= UVC_RESP_OKAY;
            rdata_reg    <= 32'h0;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            sd_prev_reg  <= 1'b0;
        end else begin
            sd_prev_reg <= sd_n_s;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_ok ? UVC_RESP_OKAY : UVC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (wr_mask) begin
                irq_mask_reg <= w_data_reg[UVC_IRQ_W-1:0];
            end
            // a new event wins over a clear in the same cycle
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_word;
                rresp_reg  <= rd_ok ? UVC_RESP_OKAY : UVC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;
endmodule : uvc_volume_step_control

// ===== uvc_button_model.sv
// partner model: push buttons on the raise and lower pins
`timescale 1ns/100ps
module uvc_button_model (
    input  wire logic aclk,
    input  wire logic press_up,
    input  wire logic press_down,
    output logic      volume_up_n,
    output logic      volume_down_n
);
    // ------------------------------------------------------------
    // a pressed button pulls its pin low
    // ------------------------------------------------------------
    initial begin
        volume_up_n = 1'b1;
        volume_down_n = 1'b1;
    end
    always @(posedge aclk) begin
        volume_up_n   <= !press_up;
        volume_down_n <= !press_down;
    end
endmodule : uvc_button_model

// ===== uvc_volume_step_control_sva.sv
// checker: concurrent properties on the volume step control ports
`timescale 1ns/100ps
module uvc_vsc_sva
    import uvc_pkg::*;
(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               volume_up_n,
    input wire logic               volume_down_n,
    input wire logic               shutdown_request_n,
    input wire logic               supply_low_lockout,
    input wire logic               short_circuit_guard,
    input wire logic               over_temp_trip,
    input wire logic               over_temp_cooled,
    input wire logic [4:0]         gain_index,
    input wire logic signed [10:0] gain_tenths_db,
    input wire logic               amp_enable,
    input wire logic               outputs_enable
);
    // ------------------------------------------------------------
    // expected gain of an index, tenths of a dB
    // ------------------------------------------------------------
    function automatic logic signed [10:0] exp_g(input logic [4:0] i);
        int v;
        v = int'(i);
        if (i == 5'h1F) v = -800;
        else if (i >= 5'h15) v = -80 - 20 * (v - 21);
        else if (i == 5'h09) v = 104;
        else v = 240 - 15 * v;
        return 11'(v);
    endfunction : exp_g

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence sd_low;
        !shutdown_request_n [*8];
    endsequence
    sequence sd_high;
        shutdown_request_n [*8];
    endsequence
    sequence all_clear;
        (shutdown_request_n && !supply_low_lockout && !short_circuit_guard && !over_temp_trip && over_temp_cooled) [*8];
    endsequence
    property one_step;
        $changed(gain_index) |-> ({1'b0, gain_index} + 6'h01 == {1'b0, $past(gain_index)})
            || ({1'b0, $past(gain_index)} + 6'h01 == {1'b0, gain_index});
    endproperty

    a_index_reset: assert property (disable iff (1'b0) !aresetn |=> gain_index == UVC_IDX_DEFAULT)
        else $error("index not preset by reset");
    a_amp_off: assert property (sd_low |-> !amp_enable) else $error("amp on in shutdown");
    a_amp_on: assert property (sd_high |-> amp_enable) else $error("amp off while running");
    a_supply_off: assert property (supply_low_lockout [*6] |-> !outputs_enable)
        else $error("outputs on at low supply");
    a_short_off: assert property (short_circuit_guard [*6] |-> !outputs_enable)
        else $error("outputs on during short");
    a_temp_off: assert property (over_temp_trip [*6] |-> !outputs_enable)
        else $error("outputs on when hot");
    a_run_clear: assert property (all_clear |-> outputs_enable)
        else $error("outputs off with no fault");
    a_step_one: assert property (one_step) else $error("index moved by more than one");
    a_idle_hold: assert property ((volume_up_n == volume_down_n) [*6] |=> $stable(gain_index))
        else $error("index moved without a single request");
    a_gain_map: assert property ($stable(gain_index) [*3] |-> gain_tenths_db == exp_g(gain_index))
        else $error("gain does not match index");
endmodule : uvc_vsc_sva

bind uvc_volume_step_control uvc_vsc_sva chk_u (.*);

// ===== testbench.sv
// testbench: volume steps, taps, shutdown, protections and register bus
`timescale 1ns/100ps
module testbench
    import uvc_pkg::*;
;
    localparam int TDL  = 3;
    localparam int ODIV = 2;
    localparam int TICK = ODIV * (1 << TDL);

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        press_up = 1'b0;
    logic        press_down = 1'b0;
    logic        shutdown_request_n = 1'b0;
    logic        supply_low_lockout = 1'b0;
    logic        short_circuit_guard = 1'b0;
    logic        over_temp_trip = 1'b0;
    logic        over_temp_cooled = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        amp_enable, outputs_enable, irq, volume_up_n, volume_down_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [4:0]  gain_index;
    logic signed [10:0] gain_tenths_db;
    int          mismatches = 0;
    int          total_checks = 0;
    int          cyc = 0;
    logic [31:0] seed = 32'hDFFC746C;
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [4:0]  expi = 5'h08;

    uvc_volume_step_control #(.TICK_DIV_LOG2(TDL), .OSC_DIV(ODIV)) dut_u (.*);
    uvc_button_model btn_u (.*);

    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask : chk

    task automatic chk_idx(input string m);
        chk(32'(gain_index), 32'(expi), m);
    endtask : chk_idx

    task automatic w(input int n);
        repeat (n) @(posedge aclk);
    endtask : w

    task automatic fin(input string s);
        $display("test %s done", s);
    endtask : fin

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(UVC_RESP_OKAY), "write resp");
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : axr

    task automatic step_wait(output int d);
        int t0;
        logic [4:0] p;
        t0 = cyc;
        p = gain_index;
        do @(posedge aclk); while (gain_index === p && cyc - t0 < 400);
        d = cyc - t0;
    endtask : step_wait

    // hold one button and time every step until saturation
    task automatic ramp(input logic up, input int n);
        int d;
        press_up <= up;
        press_down <= !up;
        for (int i = 1; i <= n; i++) begin
            step_wait(d);
            expi = up ? expi - 5'h01 : expi + 5'h01;
            chk_idx("ramp index");
            if (i == 1) chk(32'(d <= 2 * TICK + 8), 32'h1, "first step late");
            if (i == 2) chk(32'(d), 32'(UVC_SECOND_TICKS * TICK), "second step gap");
            if (i > 2) chk(32'(d), 32'(UVC_REPEAT_TICKS * TICK), "repeat gap");
        end
        step_wait(d);
        chk_idx("saturated");
        press_up <= 1'b0;
        press_down <= 1'b0;
    endtask : ramp

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        w(4);
        aresetn <= 1'b1;
        w(2);
        @(negedge aclk);
        chk_idx("reset index");
        chk(32'(gain_tenths_db), 32'h78, "reset gain");
        chk(32'(amp_enable), 32'h0, "floating shutdown");
        w(1);
        shutdown_request_n <= 1'b1;
        w(20);
        @(negedge aclk);
        chk(32'(outputs_enable), 32'h1, "running");
        fin("reset");
        axr(UVC_ADDR_MASK, rd, rs);
        chk(rd, 32'h0, "mask reset");
        axr(8'h10, rd, rs);
        chk(32'(rs), 32'(UVC_RESP_SLVERR), "unmapped resp");
        chk(rd, 32'h0, "unmapped data");
        axw(UVC_ADDR_MASK, 32'h1);
        axw(UVC_ADDR_IRQ, 32'h1F);
        @(negedge aclk);
        chk(32'(irq), 32'h0, "irq idle");
        w(1);
        press_up <= 1'b1;
        w(40);
        press_up <= 1'b0;
        w(40);
        expi = 5'h07;
        @(negedge aclk);
        chk_idx("single tap");
        chk(32'(irq), 32'h1, "irq raised");
        axw(UVC_ADDR_MASK, 32'h0);
        @(negedge aclk);
        chk(32'(irq), 32'h0, "irq masked");
        axw(UVC_ADDR_MASK, 32'h1);
        axw(UVC_ADDR_IRQ, 32'h1);
        @(negedge aclk);
        chk(32'(irq), 32'h0, "irq cleared");
        axr(UVC_ADDR_CTRL, rd, rs);
        chk(rd, 32'(expi), "index register");
        fin("registers");
        ramp(1'b1, 7);
        @(negedge aclk);
        chk(32'(gain_tenths_db), 32'hF0, "top gain");
        axr(UVC_ADDR_STAT, rd, rs);
        chk(rd, 32'hF0, "gain reg");
        w(40);
        ramp(1'b0, 31);
        @(negedge aclk);
        chk(32'(gain_tenths_db), 32'hFFFFFCE0, "bottom gain");
        w(40);
        fin("ramps");
        for (int k = 0; k < 24; k++) begin
            seed = xs(seed);
            rs = seed[1:0];
            w(1);
            press_up <= (rs != 2'h1);
            press_down <= !rs[1];
            w(24 + 8 * int'(seed[5:2]));
            press_up <= 1'b0;
            press_down <= 1'b0;
            w(40);
            if (rs == 2'h1 && expi != UVC_IDX_BOTTOM) expi++;
            if (rs[1] && expi != UVC_IDX_TOP) expi--;
            @(negedge aclk);
            chk_idx("tap");
        end
        fin("taps");
        w(1);
        shutdown_request_n <= 1'b0;
        w(20);
        @(negedge aclk);
        chk(32'({amp_enable, outputs_enable}), 32'h0, "shutdown");
        w(1);
        shutdown_request_n <= 1'b1;
        w(20);
        @(negedge aclk);
        chk(32'(amp_enable), 32'h1, "resume");
        chk_idx("index kept");
        fin("shutdown");
        for (int k = 0; k < 3; k++) begin
            w(1);
            supply_low_lockout <= (k == 0);
            short_circuit_guard <= (k == 1);
            over_temp_trip <= (k == 2);
            over_temp_cooled <= (k != 2);
            w(20);
            @(negedge aclk);
            chk(32'({amp_enable, outputs_enable}), 32'h2, "fault gate");
            w(1);
            supply_low_lockout <= 1'b0;
            short_circuit_guard <= 1'b0;
            over_temp_trip <= 1'b0;
            w(20);
            @(negedge aclk);
            chk(32'(outputs_enable), 32'(k != 2), "fault cleared");
            w(1);
            over_temp_cooled <= 1'b1;
            w(20);
            @(negedge aclk);
            chk(32'(outputs_enable), 32'h1, "recovered");
        end
        fin("protections");
        report_and_stop();
    end
endmodule : testbench
